// >>> dv/fmsu_pipe_model.sv
`timescale 1ns/100ps
// Register file side; faulted requests must leave it alone
module fmsu_pipe_model
    import fmsu_pkg::*;
(
    input wire logic clk_sys,
    input wire fmsu_rsp_s rsp
);
    logic [63:0] float_register [32];
    // Only granted writes land
    always_ff @(posedge clk_sys)
    begin
        if (rsp.write_en)
        begin
            float_register[rsp.dest_reg] <= rsp.result;
        end
    end
endmodule

// >>> dv/fmsu_select_unit_assertions.sv
`timescale 1ns/100ps
// Port checks of the selection unit
module fmsu_sel_chk
    import fmsu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire fmsu_req_s req,
    input wire logic [3:0] arch_release,
    input wire logic cop_enabled,
    input wire logic single_impl,
    input wire logic double_impl,
    input wire logic invalid_trap_en,
    input wire fmsu_rsp_s rsp,
    input wire logic [1:0] cop_unit
);
    logic hit;
    logic fmt_ok;
    // Float opcode, funct 0111xx, release six or later
    assign hit = req.valid && req.instr[31:26] == 6'h11 && req.instr[5:2] == 4'h7
        && arch_release >= 4'h6;
    assign fmt_ok = (req.instr[25:21] == 5'h10 && single_impl)
        || (req.instr[25:21] == 5'h11 && double_impl);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_done; hit |=> rsp.done; endproperty
    a_done: assert property (p_done) else $error("no answer");
    property p_skip; !hit |=> !rsp.done; endproperty
    a_skip: assert property (p_skip) else $error("stray answer");
    property p_cop; hit && !cop_enabled |=> rsp.cop_unusable && cop_unit == 2'h1; endproperty
    a_cop: assert property (p_cop) else $error("no unusable");
    property p_fmt; hit && cop_enabled && !fmt_ok |=> rsp.reserved_instr; endproperty
    a_fmt: assert property (p_fmt) else $error("no reserved");
    property p_trap; rsp.invalid_trap |-> !rsp.write_en && rsp.invalid_flag; endproperty
    a_trap: assert property (p_trap) else $error("trap wrote");
    property p_prio; rsp.write_en |-> !rsp.cop_unusable && !rsp.reserved_instr; endproperty
    a_prio: assert property (p_prio) else $error("write on fault");
    property p_pick; rsp.write_en |-> rsp.result[31:0] == $past(req.first_val[31:0])
        || rsp.result[31:0] == $past(req.second_val[31:0]); endproperty
    a_pick: assert property (p_pick) else $error("result not an input");
    property p_dest; rsp.write_en |-> rsp.dest_reg == $past(req.instr[10:6]); endproperty
    a_dest: assert property (p_dest) else $error("wrong dest");
endmodule
bind fmsu_select_unit fmsu_sel_chk i_fmsu_sel_chk (.clk_sys(clk_sys), .rst(rst), .req(req),
    .arch_release(arch_release), .cop_enabled(cop_enabled), .single_impl(single_impl),
    .double_impl(double_impl), .invalid_trap_en(invalid_trap_en), .rsp(rsp),
    .cop_unit(cop_unit));

// >>> dv/fmsu_select_unit_tb.sv
`timescale 1ns/100ps
module fmsu_select_unit_tb
    import fmsu_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    fmsu_req_s req = '0;
    logic [3:0] arch_release = 4'h6;
    logic cop_enabled = 1'b1;
    logic single_impl = 1'b1;
    logic double_impl = 1'b1;
    logic invalid_trap_en = 1'b0;
    fmsu_rsp_s rsp;
    logic [1:0] cop_unit;
    int err_count = 0;
    int samples_checked = 0;
    logic [5:0] fn [4] = '{6'h1e, 6'h1c, 6'h1f, 6'h1d};
    // 20 MHz
    always #25 clk_sys = ~clk_sys;
    fmsu_select_unit i_fmsu_select_unit (.clk_sys(clk_sys), .rst(rst), .req(req),
        .arch_release(arch_release), .cop_enabled(cop_enabled), .single_impl(single_impl),
        .double_impl(double_impl), .invalid_trap_en(invalid_trap_en), .rsp(rsp),
        .cop_unit(cop_unit));
    fmsu_pipe_model i_fmsu_pipe_model (.clk_sys(clk_sys), .rsp(rsp));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Answer is registered, so read it just after the following edge
    task automatic run(input logic [5:0] f, input logic [4:0] fmt, input logic [63:0] a, b);
        @(posedge clk_sys);
        req <= '{1'b1, {6'h11, fmt, 5'h2, 5'h1, 5'h3, f}, a, b};
        @(posedge clk_sys);
        req.valid <= 1'b0;
        #1;
    endtask
    // Signed zeros both ways, magnitude tie and plain order
    task automatic t_order();
        for (int i = 0; i < 4; i++)
        begin
            run(fn[i], 5'h10, 64'h80000000, 64'h0);
            check(rsp.result, i % 2 ? 64'h80000000 : 64'h0);
            run(fn[i], 5'h10, 64'h0, 64'h80000000);
            check(rsp.result, i % 2 ? 64'h80000000 : 64'h0);
            run(fn[i], 5'h10, 64'hc0000000, 64'h40000000);
            check(rsp.result, i % 2 ? 64'hc0000000 : 64'h40000000);
            run(fn[i], 5'h10, 64'h3f800000, 64'hc0000000);
            check(rsp.result, (i == 0 || i == 3) ? 64'h3f800000 : 64'hc0000000);
            check(rsp.unimpl_flag, 64'h0);
        end
        $display("order test over");
    endtask
    // Doubles: one NaN, then two NaNs
    task automatic t_nan();
        for (int i = 0; i < 4; i++)
        begin
            run(fn[i], 5'h11, 64'h7ff8000000000001, 64'h3ff0000000000000);
            check(rsp.result, 64'h3ff0000000000000);
            run(fn[i], 5'h11, 64'h7ff8000000000001, 64'hfff8000000000002);
            check(rsp.result, 64'h7ff8000000000001);
        end
        $display("nan test over");
    endtask
    // Signalling NaN untrapped, then trapped
    task automatic t_snan();
        run(fn[0], 5'h10, 64'h7fa00000, 64'h3f800000);
        check(rsp.invalid_flag, 64'h1);
        run(fn[1], 5'h10, 64'h7fa00000, 64'h7fc00000);
        check(rsp.result, 64'h7fa00000);
        @(posedge clk_sys);
        invalid_trap_en <= 1'b1;
        run(fn[2], 5'h10, 64'h3f800000, 64'h7fa00000);
        check({rsp.invalid_trap, rsp.write_en}, 64'h2);
        check(i_fmsu_pipe_model.float_register[3], 64'h7fa00000);
        @(posedge clk_sys);
        invalid_trap_en <= 1'b0;
        $display("snan test over");
    endtask
    // Disabled unit wins over bad format; missing format; old release
    task automatic t_refuse();
        @(posedge clk_sys);
        cop_enabled <= 1'b0;
        double_impl <= 1'b0;
        run(fn[3], 5'h14, 64'h0, 64'h0);
        check({rsp.cop_unusable, cop_unit, rsp.reserved_instr, rsp.write_en}, 64'h14);
        @(posedge clk_sys);
        cop_enabled <= 1'b1;
        run(fn[3], 5'h11, 64'h0, 64'h0);
        check({rsp.reserved_instr, rsp.unimpl_flag, rsp.write_en}, 64'h6);
        @(posedge clk_sys);
        double_impl <= 1'b1;
        arch_release <= 4'h5;
        run(fn[0], 5'h10, 64'h0, 64'h0);
        check(rsp.done, 64'h0);
        $display("refuse test over");
    endtask
    task automatic end_of_test();
        $display("checked %0d bad %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_order();
        t_nan();
        t_snan();
        t_refuse();
        end_of_test();
    end
    // Watchdog: the run needs some 70 cycles
    initial
    begin
        #40000;
        err_count++;
        end_of_test();
    end
endmodule

// >>> logic/fmsu_compare.sv
`timescale 1ns/100ps
`include "fmsu_defs.svh"
// Pure combinational chooser for both formats
module fmsu_compare
    import fmsu_pkg::*;
(
    input wire logic is_double,
    input wire fmsu_op_e op,
    input wire logic [63:0] a,
    input wire logic [63:0] b,
    output logic a_nan,
    output logic b_nan,
    output logic a_snan,
    output logic b_snan,
    output logic pick_a
);
    logic sa;
    logic sb;
    logic [62:0] ma;
    logic [62:0] mb;
    logic a_mag_gt;
    logic mag_eq;
    logic a_signed_gt;
    logic signed_eq;

    // Split sign and magnitude per format; single sits in the low word
    always_comb
    begin
        if (is_double)
        begin
            sa = a[`FMSU_D_SIGN];
            sb = b[`FMSU_D_SIGN];
            ma = a[62:0];
            mb = b[62:0];
            a_nan = (a[62:52] == 11'h7ff) && (a[51:0] != 52'h0);
            b_nan = (b[62:52] == 11'h7ff) && (b[51:0] != 52'h0);
            a_snan = a_nan && !a[`FMSU_D_QUIET];
            b_snan = b_nan && !b[`FMSU_D_QUIET];
        end
        else
        begin
            sa = a[`FMSU_S_SIGN];
            sb = b[`FMSU_S_SIGN];
            ma = {32'h0, a[30:0]};
            mb = {32'h0, b[30:0]};
            a_nan = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
            b_nan = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
            a_snan = a_nan && !a[`FMSU_S_QUIET];
            b_snan = b_nan && !b[`FMSU_S_QUIET];
        end
    end

    // Sign-magnitude ordering; -0 sorts below +0 on purpose
    always_comb
    begin
        a_mag_gt = ma > mb;
        mag_eq = ma == mb;
        signed_eq = mag_eq && (sa == sb);
        if (sa != sb)
            a_signed_gt = !sa;
        else if (sa)
            a_signed_gt = mb > ma;
        else
            a_signed_gt = a_mag_gt;
    end

    // Operation choice; ties of equal values pick the first operand
    always_comb
    begin
        case (op)
            FMSU_OP_MAX: pick_a = a_signed_gt || signed_eq;
            FMSU_OP_MIN: pick_a = !a_signed_gt;
            FMSU_OP_MAXA: pick_a = a_mag_gt || (mag_eq && (a_signed_gt || signed_eq));
            FMSU_OP_MINA: pick_a = (!a_mag_gt && !mag_eq) || (mag_eq && !a_signed_gt);
            default: pick_a = 1'b1;
        endcase
    end
endmodule

// >>> logic/fmsu_select_unit.sv
`timescale 1ns/100ps
`include "fmsu_defs.svh"
// Function
// - Decode only for release six onward
// - Coprocessor disabled raises unusable, unit 1
// - Unimplemented format raises reserved instruction
// - Signalling NaN flags invalid operand
// - One NaN returns the numeric operand
// - Both NaN returns first source
// - Max returns larger, min smaller
// - Max-magnitude returns larger absolute value
// - Magnitude tie: max-magnitude returns larger signed
// - Min-magnitude smaller absolute, tie smaller signed
// - Plus and minus zero ordered by sign
// - Signalling NaN with trap: exception, no write
// - Only unimplemented and invalid flags reported
// - Write result in operand format
// - Decode float opcode and four function codes
// - Single and double formats supported
module fmsu_select_unit
    import fmsu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire fmsu_req_s req,
    input wire logic [3:0] arch_release,
    input wire logic cop_enabled,
    input wire logic single_impl,
    input wire logic double_impl,
    input wire logic invalid_trap_en,
    output fmsu_rsp_s rsp,
    output logic [1:0] cop_unit
);
    logic [5:0] opc;
    logic [5:0] fn;
    logic [4:0] fmt;
    logic is_sel;
    logic is_double;
    logic fmt_ok;
    fmsu_op_e op;
    logic a_nan;
    logic b_nan;
    logic a_snan;
    logic b_snan;
    logic pick_a;
    logic take_a;
    logic any_snan;
    logic [63:0] chosen;
    fmsu_rsp_s next_rsp;
    logic rsp_done;
    logic rsp_write_en;
    logic [4:0] rsp_dest_reg;
    logic [31:0] rsp_result_hi;
    logic [31:0] rsp_result_lo;
    logic rsp_cop_unusable;
    logic rsp_reserved_instr;
    logic rsp_invalid_trap;
    logic rsp_invalid_flag;
    logic rsp_unimpl_flag;

    // Instruction field extraction
    assign opc = req.instr[`FMSU_OPC_HI:`FMSU_OPC_LO];
    assign fn = req.instr[`FMSU_FN_HI:`FMSU_FN_LO];
    assign fmt = req.instr[`FMSU_FMT_HI:`FMSU_FMT_LO];

    // Decode; older releases see nothing here and the pipeline handles it
    always_comb
    begin
        is_sel = (opc == `FMSU_OPC_FLOAT) && (arch_release >= `FMSU_RELEASE_MIN);
        op = FMSU_OP_MAX;
        case (fn)
            `FMSU_FN_MAX: op = FMSU_OP_MAX;
            `FMSU_FN_MAXA: op = FMSU_OP_MAXA;
            `FMSU_FN_MIN: op = FMSU_OP_MIN;
            `FMSU_FN_MINA: op = FMSU_OP_MINA;
            default: is_sel = 1'b0;
        endcase
    end

    // Format check: only S and D exist and each may be absent
    assign is_double = fmt == `FMSU_FMT_D;
    assign fmt_ok = ((fmt == `FMSU_FMT_S) && single_impl) || (is_double && double_impl);

    fmsu_compare u_compare
    (
        .is_double(is_double),
        .op(op),
        .a(req.first_val),
        .b(req.second_val),
        .a_nan(a_nan),
        .b_nan(b_nan),
        .a_snan(a_snan),
        .b_snan(b_snan),
        .pick_a(pick_a)
    );

    // NaN preference ahead of the numeric compare
    always_comb
    begin
        any_snan = a_snan || b_snan;
        if (a_nan && b_nan)
            take_a = 1'b1;
        else if (a_nan)
            take_a = 1'b0;
        else if (b_nan)
            take_a = 1'b1;
        else
            take_a = pick_a;
        // No quieting, no rounding: the raw source bits go out
        chosen = take_a ? req.first_val : req.second_val;
        if (!is_double)
            chosen = {32'h0, chosen[31:0]};
    end

    // Answer assembly with the check priority of the pipeline
    always_comb
    begin
        next_rsp = '0;
        next_rsp.dest_reg = req.instr[`FMSU_FD_HI:`FMSU_FD_LO];
        next_rsp.result = chosen;
        if (req.valid && is_sel)
        begin
            next_rsp.done = 1'b1;
            if (!cop_enabled)
                next_rsp.cop_unusable = 1'b1;
            else if (!fmt_ok)
            begin
                next_rsp.reserved_instr = 1'b1;
                next_rsp.unimpl_flag = 1'b1;
            end
            else if (any_snan && invalid_trap_en)
            begin
                next_rsp.invalid_flag = 1'b1;
                next_rsp.invalid_trap = 1'b1;
            end
            else
            begin
                next_rsp.invalid_flag = any_snan;
                next_rsp.write_en = 1'b1;
            end
        end
        if (!next_rsp.write_en)
            next_rsp.result = `FMSU_RST_WORD;
    end

    // Completion pulse, one cycle after the request
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_done <= 1'b0;
        else
            rsp_done <= next_rsp.done;
    end

    // Write grant; low whenever any check refused the request
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_write_en <= 1'b0;
        else
            rsp_write_en <= next_rsp.write_en;
    end

    // Destination index travels with the result
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_dest_reg <= 5'h0;
        else
            rsp_dest_reg <= next_rsp.dest_reg;
    end

    // High word only carries data for double operands
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_result_hi <= 32'h0;
        else
            rsp_result_hi <= next_rsp.result[63:32];
    end

    // Low word holds single results and the double's low half
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_result_lo <= 32'h0;
        else
            rsp_result_lo <= next_rsp.result[31:0];
    end

    // Coprocessor disabled fault
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_cop_unusable <= 1'b0;
        else
            rsp_cop_unusable <= next_rsp.cop_unusable;
    end

    // Format fault; kept apart so the pipeline can tell it from a trap
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_reserved_instr <= 1'b0;
        else
            rsp_reserved_instr <= next_rsp.reserved_instr;
    end

    // Trapped signalling operand
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_invalid_trap <= 1'b0;
        else
            rsp_invalid_trap <= next_rsp.invalid_trap;
    end

    // Invalid-operand flag, trapped or not
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_invalid_flag <= 1'b0;
        else
            rsp_invalid_flag <= next_rsp.invalid_flag;
    end

    // Unimplemented-operation flag
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_unimpl_flag <= 1'b0;
        else
            rsp_unimpl_flag <= next_rsp.unimpl_flag;
    end

    // Answer is pure wiring of the flops above, no logic after them
    assign rsp = '{
        done: rsp_done,
        write_en: rsp_write_en,
        dest_reg: rsp_dest_reg,
        result: {rsp_result_hi, rsp_result_lo},
        cop_unusable: rsp_cop_unusable,
        reserved_instr: rsp_reserved_instr,
        invalid_trap: rsp_invalid_trap,
        invalid_flag: rsp_invalid_flag,
        unimpl_flag: rsp_unimpl_flag
    };

    // Coprocessor number travels with the unusable exception
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cop_unit <= 2'h0;
        else
            cop_unit <= next_rsp.cop_unusable ? 2'h1 : 2'h0;
    end
endmodule

// >>> pkg/fmsu_defs.svh
`ifndef FMSU_DEFS_SVH
`define FMSU_DEFS_SVH
// Instruction word fields
`define FMSU_OPC_HI 31
`define FMSU_OPC_LO 26
`define FMSU_FMT_HI 25
`define FMSU_FMT_LO 21
`define FMSU_FT_HI 20
`define FMSU_FT_LO 16
`define FMSU_FS_HI 15
`define FMSU_FS_LO 11
`define FMSU_FD_HI 10
`define FMSU_FD_LO 6
`define FMSU_FN_HI 5
`define FMSU_FN_LO 0
// Encodings
`define FMSU_OPC_FLOAT 6'h11
`define FMSU_FN_MAX 6'h1e
`define FMSU_FN_MAXA 6'h1f
`define FMSU_FN_MIN 6'h1c
`define FMSU_FN_MINA 6'h1d
`define FMSU_FMT_S 5'h10
`define FMSU_FMT_D 5'h11
// Architecture release that owns the selection operations
`define FMSU_RELEASE_MIN 4'h6
// Sign and quiet bit positions; single precision inside the low word
`define FMSU_S_SIGN 31
`define FMSU_S_QUIET 22
`define FMSU_D_SIGN 63
`define FMSU_D_QUIET 51
// Reset values
`define FMSU_RST_WORD 64'h0
`endif

// >>> pkg/fmsu_pkg.sv
package fmsu_pkg;
    typedef enum logic [1:0] {FMSU_OP_MAX, FMSU_OP_MIN, FMSU_OP_MAXA, FMSU_OP_MINA} fmsu_op_e;

    // Request from the pipeline: instruction plus both operand values
    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [63:0] first_val;
        logic [63:0] second_val;
    } fmsu_req_s;

    // Answer to the pipeline
    typedef struct packed {
        logic done;
        logic write_en;
        logic [4:0] dest_reg;
        logic [63:0] result;
        logic cop_unusable;
        logic reserved_instr;
        logic invalid_trap;
        logic invalid_flag;
        logic unimpl_flag;
    } fmsu_rsp_s;
endpackage
